// ===== verilog/encoder_result_register_bank.sv
// Purpose: user register bank of a rotary angle encoder, reached through a serial slave port
// Assumes: converter results and flags arrive on sys_clk; conv_done pulses once per conversion
// Notes: responses are prepared when select rises and shifted out in the next packet
`include "encoder_params.svh"

module encoder_result_register_bank (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic si,
  output logic so,
  output logic so_oe_n,
  output logic conv_start,
  input wire logic conv_busy,
  input wire logic conv_done,
  input wire logic [9:0] res_angle,
  input wire logic [11:0] res_sine,
  input wire logic [11:0] res_cosine,
  input wire logic [9:0] res_sensor_a,
  input wire logic [9:0] res_sensor_b,
  input wire logic [9:0] res_sensor_c,
  input wire logic adc_oflo,
  input wire logic adc_uflo,
  output logic [4:0] gain_level,
  output logic cfg_sample_rise,
  output logic cfg_spi_sample_off,
  output logic cfg_irq_or,
  output logic cfg_agc_off,
  output logic cfg_low_power
);

  logic [1:0] rst_q;
  logic rst_sync_n;
  logic cmd_valid;
  logic [15:0] cmd_word;
  logic [5:0] cmd_addr;
  logic cmd_wr;
  logic cmd_sup;
  logic err;
  encoder_pkg::bank_state_t st_r;
  encoder_pkg::bank_state_t st_nxt;

  // limits a signed trig component to its legal swing
  function automatic logic [11:0] trig_clamp(input logic [11:0] v);
    logic [11:0] neg_lim;
    neg_lim = 12'h0000 - `TRIG_LIMIT;
    if (!v[11] && v > `TRIG_LIMIT) begin
      trig_clamp = `TRIG_LIMIT;
    end else if (v[11] && v < neg_lim) begin
      trig_clamp = neg_lim;
    end else begin
      trig_clamp = v;
    end
  endfunction

  // common layout of the six sixteen-bit result words
  function automatic logic [15:0] result_word(input logic busy, input logic e, input logic [13:0] body);
    result_word = {busy, e, body};
  endfunction

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_q[1];

  spi_cmd_shifter u_shifter (
    .sys_clk(sys_clk),
    .rst_sync_n(rst_sync_n),
    .sclk(sclk),
    .ss_n(ss_n),
    .si(si),
    .resp_word(st_r.resp),
    .resp_load(st_r.load),
    .so(so),
    .so_oe_n(so_oe_n),
    .cmd_valid(cmd_valid),
    .cmd_word(cmd_word)
  );

  assign cmd_addr = cmd_word[`CMD_ADDR_HI:`CMD_ADDR_LO];
  assign cmd_wr = cmd_word[`CMD_WR_BIT];
  assign cmd_sup = cmd_word[`CMD_SUP_BIT];
  assign err = st_r.oflo | st_r.uflo;

  always_comb begin
    st_nxt = st_r;
    st_nxt.load = cmd_valid;
    st_nxt.start = 1'b0;
    if (conv_done) begin
      st_nxt.angle = res_angle;
      st_nxt.sine = trig_clamp(res_sine);
      st_nxt.cosine = trig_clamp(res_cosine);
      st_nxt.sens_a = res_sensor_a;
      st_nxt.sens_b = res_sensor_b;
      st_nxt.sens_c = res_sensor_c;
      st_nxt.oflo = adc_oflo;
      st_nxt.uflo = adc_uflo;
      if (!st_r.cfg[`CFG_NOAGC_BIT]) begin
        if (adc_oflo && st_r.gain != 5'h00) begin
          st_nxt.gain = st_r.gain - 5'h01;
        end else if (adc_uflo && !adc_oflo && st_r.gain < `GAIN_MAX) begin
          st_nxt.gain = st_r.gain + 5'h01;
        end
      end
    end
    if (cmd_valid) begin
      st_nxt.start = ~cmd_sup & ~st_r.cfg[`CFG_SMOD_BIT];
      st_nxt.resp = 16'h0000;
      if (cmd_wr) begin
        // a write answers zero; only two offsets store anything
        if (cmd_addr == `ADDR_CONFIG) begin
          st_nxt.cfg = cmd_word[7:0] & `CFG_WRITE_MASK;
        end else if (cmd_addr == `ADDR_GAIN) begin
          st_nxt.gain = (cmd_word[4:0] > `GAIN_MAX) ? `GAIN_MAX : cmd_word[4:0];
        end
      end else begin
        // busy is taken live so a read during a conversion shows it
        unique case (cmd_addr)
          `ADDR_ANGLE: st_nxt.resp = result_word(conv_busy, err, {st_r.gain[4:1], st_r.angle});
          `ADDR_SINE: st_nxt.resp = result_word(conv_busy, err, {2'h0, st_r.sine});
          `ADDR_COSINE: st_nxt.resp = result_word(conv_busy, err, {2'h0, st_r.cosine});
          `ADDR_SENSOR_A: st_nxt.resp = result_word(conv_busy, err, {4'h0, st_r.sens_a});
          `ADDR_SENSOR_B: st_nxt.resp = result_word(conv_busy, err, {4'h0, st_r.sens_b});
          `ADDR_SENSOR_C: st_nxt.resp = result_word(conv_busy, err, {4'h0, st_r.sens_c});
          `ADDR_CHIP_ID: st_nxt.resp = {8'h00, `CHIP_REV, `CHIP_IDENT};
          `ADDR_CONFIG: st_nxt.resp = {8'h00, st_r.cfg};
          `ADDR_STATE: st_nxt.resp = {8'h00, 5'h00, st_r.uflo, st_r.oflo, conv_busy};
          `ADDR_GAIN: st_nxt.resp = {8'h00, 3'h0, st_r.gain};
          default: st_nxt.resp = 16'h0000;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_r <= '0;
      st_r.cfg <= `CFG_RESET;
      st_r.gain <= `GAIN_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign conv_start = st_r.start;
  assign gain_level = st_r.gain;
  assign cfg_sample_rise = st_r.cfg[`CFG_SPOL_BIT];
  assign cfg_spi_sample_off = st_r.cfg[`CFG_SMOD_BIT];
  assign cfg_irq_or = st_r.cfg[`CFG_IMOD_BIT];
  assign cfg_agc_off = st_r.cfg[`CFG_NOAGC_BIT];
  assign cfg_low_power = st_r.cfg[`CFG_LPWR_BIT];

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_sync_n);

  sup_blocks_start_a: assert property (cmd_valid && cmd_sup |=> !conv_start)
    else $error("sample started despite suppress bit");
  start_has_cause_a: assert property (conv_start |-> $past(cmd_valid) && !$past(cmd_sup))
    else $error("sample started without an unsuppressed command");
  start_one_cycle_a: assert property (conv_start |=> !conv_start)
    else $error("sample start longer than one cycle");
  write_guard_a: assert property (cmd_valid && cmd_wr && cmd_addr != `ADDR_CONFIG
      && cmd_addr != `ADDR_GAIN && !conv_done |=> $stable(st_r.cfg) && $stable(st_r.gain))
    else $error("write to a read-only offset changed state");
  config_write_a: assert property (cmd_valid && cmd_wr && cmd_addr == `ADDR_CONFIG
      |=> st_r.cfg == ($past(cmd_word[7:0]) & `CFG_WRITE_MASK))
    else $error("configuration write not stored");
  gain_write_a: assert property (cmd_valid && cmd_wr && cmd_addr == `ADDR_GAIN
      |=> gain_level == (($past(cmd_word[4:0]) > `GAIN_MAX) ? `GAIN_MAX : $past(cmd_word[4:0])))
    else $error("gain write not stored");
  reserved_read_a: assert property (cmd_valid && !cmd_wr && (cmd_addr > `ADDR_GAIN
      || (cmd_addr > `ADDR_SENSOR_C && cmd_addr < `ADDR_CHIP_ID)) |=> st_r.resp == 16'h0000)
    else $error("reserved offset answered nonzero");
  angle_read_a: assert property (cmd_valid && !cmd_wr && cmd_addr == `ADDR_ANGLE
      |=> st_r.resp[9:0] == $past(st_r.angle) && st_r.resp[13:10] == $past(st_r.gain[4:1])
      && st_r.resp[15] == $past(conv_busy) ##1 so == st_r.resp[15])
    else $error("angle response wrong");
  busy_bit_a: assert property (cmd_valid && !cmd_wr && cmd_addr <= `ADDR_SENSOR_C
      |=> st_r.resp[15] == $past(conv_busy))
    else $error("busy flag of result word wrong");
  err_capture_a: assert property (conv_done |=> err == $past(adc_oflo | adc_uflo))
    else $error("error flag not taken from the finished conversion");
  error_bit_a: assert property (cmd_valid && !cmd_wr && cmd_addr == `ADDR_SINE
      |=> st_r.resp[14] == $past(st_r.oflo | st_r.uflo) && st_r.resp[13:12] == 2'h0)
    else $error("sine response flags wrong");
  cosine_read_a: assert property (cmd_valid && !cmd_wr && cmd_addr == `ADDR_COSINE
      |=> st_r.resp[11:0] == $past(st_r.cosine) && st_r.resp[13:12] == 2'h0)
    else $error("cosine response wrong");
  trig_bound_a: assert property (conv_done ##1 1'b1 |-> (st_r.sine[11] ? (st_r.sine >= 12'hA03)
      : (st_r.sine <= `TRIG_LIMIT)) && (st_r.cosine[11] ? (st_r.cosine >= 12'hA03)
      : (st_r.cosine <= `TRIG_LIMIT)))
    else $error("trig value beyond limit");
  status_read_a: assert property (cmd_valid && !cmd_wr && cmd_addr == `ADDR_STATE
      |=> st_r.resp == {13'h0000, $past(st_r.uflo), $past(st_r.oflo), $past(conv_busy)})
    else $error("status response wrong");
  agc_down_a: assert property (conv_done && adc_oflo && !cfg_agc_off && gain_level != 5'h00
      && !cmd_valid |=> gain_level == $past(gain_level) - 5'h01)
    else $error("gain not lowered on overflow");
  agc_up_a: assert property (conv_done && adc_uflo && !adc_oflo && !cfg_agc_off
      && gain_level < `GAIN_MAX && !cmd_valid |=> gain_level == $past(gain_level) + 5'h01)
    else $error("gain not raised on underflow");
  byte_regs_a: assert property (cmd_valid && !cmd_wr && cmd_addr[5] |=> st_r.resp[15:8] == 8'h00)
    else $error("byte register response has upper bits set");

endmodule

// ===== verilog/encoder_params.svh
// Purpose: register offsets, field positions and reset values of the encoder register bank
// Assumes: six-bit register addresses, sixteen-bit response words
// Notes: definitions only
`ifndef ENCODER_PARAMS_SVH
`define ENCODER_PARAMS_SVH

`define ADDR_ANGLE 6'h00
`define ADDR_SINE 6'h01
`define ADDR_COSINE 6'h02
`define ADDR_SENSOR_A 6'h03
`define ADDR_SENSOR_B 6'h04
`define ADDR_SENSOR_C 6'h05
`define ADDR_CHIP_ID 6'h20
`define ADDR_CONFIG 6'h21
`define ADDR_STATE 6'h22
`define ADDR_GAIN 6'h23

`define CMD_SUP_BIT 15
`define CMD_WR_BIT 14
`define CMD_ADDR_HI 13
`define CMD_ADDR_LO 8

`define RES_BUSY_BIT 15
`define RES_ERR_BIT 14

`define CFG_LPWR_BIT 0
`define CFG_NOAGC_BIT 2
`define CFG_IMOD_BIT 3
`define CFG_SMOD_BIT 5
`define CFG_SPOL_BIT 6
`define CFG_WRITE_MASK 8'h6D
`define CFG_RESET 8'h00

`define GAIN_RESET 5'h08
`define GAIN_MAX 5'h11

`define TRIG_LIMIT 12'h05FD

// identification fields: values are arbitrary
`define CHIP_REV 4'h1
`define CHIP_IDENT 4'h3

`endif

// ===== verilog/encoder_pkg.sv
// Purpose: state types of the encoder register bank
// Assumes: nothing beyond the parameter header
// Notes: one packed struct per module holds its state, apart from the reset synchroniser rst_q of the bank
package encoder_pkg;

  typedef struct packed {
    logic [1:0] sclk_s;
    logic [1:0] ss_s;
    logic [1:0] si_s;
    logic sclk_d;
    logic ss_d;
    logic [15:0] shin;
    logic [15:0] shout;
    logic [15:0] cmd;
    logic valid;
  } shifter_state_t;

  typedef struct packed {
    logic [15:0] resp;
    logic load;
    logic start;
    logic [9:0] angle;
    logic [11:0] sine;
    logic [11:0] cosine;
    logic [9:0] sens_a;
    logic [9:0] sens_b;
    logic [9:0] sens_c;
    logic oflo;
    logic uflo;
    logic [7:0] cfg;
    logic [4:0] gain;
  } bank_state_t;

endpackage

// ===== verilog/spi_cmd_shifter.sv
// Purpose: mode 0 serial slave that gathers 16-bit commands and shifts out responses
// Assumes: serial clock at most one eighth of sys_clk, all pins synchronised here
// Notes: a packet shorter than 16 bits is taken as whatever sits in the shifter
module spi_cmd_shifter (
  input wire logic sys_clk,
  input wire logic rst_sync_n,
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic si,
  input wire logic [15:0] resp_word,
  input wire logic resp_load,
  output logic so,
  output logic so_oe_n,
  output logic cmd_valid,
  output logic [15:0] cmd_word
);

  encoder_pkg::shifter_state_t st_r;
  encoder_pkg::shifter_state_t st_nxt;
  logic rise;
  logic fall;
  logic ss_end;

  // edges come from the second sync stage against its delayed copy only
  assign rise = st_r.sclk_s[1] & ~st_r.sclk_d;
  assign fall = ~st_r.sclk_s[1] & st_r.sclk_d;
  assign ss_end = st_r.ss_s[1] & ~st_r.ss_d;

  always_comb begin
    st_nxt = st_r;
    st_nxt.sclk_s = {st_r.sclk_s[0], sclk};
    st_nxt.ss_s = {st_r.ss_s[0], ss_n};
    st_nxt.si_s = {st_r.si_s[0], si};
    st_nxt.sclk_d = st_r.sclk_s[1];
    st_nxt.ss_d = st_r.ss_s[1];
    st_nxt.valid = 1'b0;
    if (!st_r.ss_s[1] && rise) begin
      st_nxt.shin = {st_r.shin[14:0], st_r.si_s[1]};
    end
    if (!st_r.ss_s[1] && fall) begin
      st_nxt.shout = {st_r.shout[14:0], 1'b0};
    end
    if (ss_end) begin
      st_nxt.cmd = st_r.shin;
      st_nxt.valid = 1'b1;
    end
    if (resp_load) begin
      st_nxt.shout = resp_word;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_r <= '0;
      st_r.ss_s <= 2'h3;
      st_r.ss_d <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign so = st_r.shout[15];
  assign so_oe_n = st_r.ss_s[1];
  assign cmd_valid = st_r.valid;
  assign cmd_word = st_r.cmd;

endmodule

// ===== test/conv_model.sv
// Purpose: converter stand-in, a busy span and a done pulse for each start
// Assumes: the bench holds result values steady while busy
// Notes: span length from conv_len so slow conversions can be forced
module conv_model (
  input wire logic sys_clk,
  input wire logic conv_start,
  input wire logic [9:0] conv_len,
  output logic conv_busy,
  output logic conv_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] left = 10'h000;
  initial begin
    conv_busy = 1'b0;
    conv_done = 1'b0;
  end
  always @(posedge sys_clk) begin
    conv_done <= 1'b0;
    if (conv_start === 1'b1) begin
      conv_busy <= 1'b1;
      left <= conv_len;
    end else if (conv_busy && left <= 10'h001) begin
      conv_busy <= 1'b0;
      conv_done <= 1'b1;
    end else if (conv_busy)
      left <= left - 10'h001;
  end
endmodule

// ===== test/encoder_result_register_bank_tb.sv
// Purpose: self-checking bench of the encoder register bank
// Assumes: host speaks mode 0 serial; converter is conv_model
// Notes: answers are queued per packet and checked as each packet ends
`include "encoder_params.svh"
module encoder_result_register_bank_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0, rst_n = 1'b0, sclk = 1'b0, ss_n = 1'b1, si = 1'b0, so, so_oe_n;
  logic conv_start, conv_busy, conv_done, adc_oflo = 1'b0, adc_uflo = 1'b0, rs, sf, io, ao, lp;
  logic eo = 1'b0, eu = 1'b0;
  logic [9:0] res_angle = '0, res_sensor_a = '0, res_sensor_b = '0, res_sensor_c = '0, clen = 10'h014;
  logic [11:0] res_sine = '0, res_cosine = '0;
  logic [4:0] gain_level, g = 5'h08, r;
  logic [7:0] ec = 8'h00;
  logic [15:0] rx, pv = '0, pm = '0;
  logic [31:0] q[$];
  logic [5:0] am[14] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h1F, 6'h20, 6'h21, 6'h22, 6'h23,
    6'h24, 6'h3F};
  int n_fail = 0, n_compared = 0, seed = 93, n_st = 0, e_st = 0;
  event pkt;

  encoder_result_register_bank u_encoder_result_register_bank (.sys_clk, .rst_n, .sclk, .ss_n, .si, .so,
    .so_oe_n, .conv_start, .conv_busy, .conv_done, .res_angle, .res_sine, .res_cosine, .res_sensor_a,
    .res_sensor_b, .res_sensor_c, .adc_oflo, .adc_uflo, .gain_level, .cfg_sample_rise(rs),
    .cfg_spi_sample_off(sf), .cfg_irq_or(io), .cfg_agc_off(ao), .cfg_low_power(lp));
  conv_model u_conv_model (.sys_clk, .conv_start, .conv_len(clen), .conv_busy, .conv_done);

  initial forever #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (conv_start === 1'b1) n_st++;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // each packet carries the answer to the one before
  task automatic xfer(input logic [15:0] c, input logic [15:0] e, input logic [15:0] m);
    q.push_back({pm, pv});
    ss_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      si = c[i];
      cyc(5);
      rx[i] = so;
      if (i == 15) chk({15'h0000, so_oe_n}, 16'h0000);
      sclk = 1'b1;
      cyc(5);
      sclk = 1'b0;
    end
    cyc(5);
    ss_n = 1'b1;
    -> pkt;
    cyc(40);
    chk({15'h0000, so_oe_n}, 16'h0001);
    pv = e;
    pm = m;
    if (!c[15] && !ec[5]) e_st++;
  endtask
  always @(pkt) begin
    logic [31:0] t;
    t = q.pop_front();
    chk(rx & t[31:16], t[15:0]);
  end
  function automatic logic [11:0] clp(input logic [11:0] x);
    if ($signed(x) > $signed(12'h5FD)) return 12'h5FD;
    if ($signed(x) < $signed(12'hA03)) return 12'hA03;
    return x;
  endfunction
  function automatic logic [15:0] ex(input logic [5:0] a);
    case (a)
      `ADDR_ANGLE: return {1'b0, eo | eu, g[4:1], res_angle};
      `ADDR_SINE: return {1'b0, eo | eu, 2'b00, clp(res_sine)};
      `ADDR_COSINE: return {1'b0, eo | eu, 2'b00, clp(res_cosine)};
      `ADDR_SENSOR_A: return {1'b0, eo | eu, 4'h0, res_sensor_a};
      `ADDR_SENSOR_B: return {1'b0, eo | eu, 4'h0, res_sensor_b};
      `ADDR_SENSOR_C: return {1'b0, eo | eu, 4'h0, res_sensor_c};
      `ADDR_CHIP_ID: return {8'h00, `CHIP_REV, `CHIP_IDENT};
      `ADDR_CONFIG: return {8'h00, ec};
      `ADDR_STATE: return {13'h0000, eu, eo, 1'b0};
      `ADDR_GAIN: return {11'h000, g};
      default: return 16'h0000;
    endcase
  endfunction
  // sup set keeps sine and cosine tied to the last angle
  function automatic logic [15:0] rd(input logic [5:0] a);
    return {2'b10, a, 8'h00};
  endfunction
  task automatic rdall;
    foreach (am[i])
      xfer(rd(am[i]), ex(am[i]), 16'hFFFF);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    xfer({2'b11, a, d}, 16'h0000, 16'hFFFF);
    if (a == `ADDR_CONFIG)
      ec = d & 8'h6D;
    if (a == `ADDR_GAIN)
      g = (d > 8'h11) ? 5'h11 : d[4:0];
  endtask
  task automatic smp(input logic o, input logic u, input logic x);
    res_angle = 10'($random(seed));
    res_sine = x ? 12'h7FF : 12'($random(seed));
    res_cosine = x ? 12'h800 : 12'($random(seed));
    res_sensor_a = 10'($random(seed));
    res_sensor_b = 10'($random(seed));
    res_sensor_c = 10'($random(seed));
    adc_oflo = o;
    adc_uflo = u;
    xfer({2'b00, `ADDR_STATE, 8'h00}, ex(`ADDR_STATE), 16'hFFFF);
    eo = o;
    eu = u;
    if (!ec[2] && o && g != 5'h00) g = g - 5'h01;
    else if (!ec[2] && !o && u && g < 5'h11) g = g + 5'h01;
  endtask
  task automatic give_verdict;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #600000;
    n_fail++;
    give_verdict;
  end
  initial begin
    cyc(10);
    rst_n = 1'b1;
    cyc(6);
    for (int i = 0; i < 3; i++) begin
      smp(1'b0, 1'b0, i == 2);
      rdall();
    end
    $display("test results done");
    smp(1'b1, 1'b0, 1'b0);
    rdall();
    smp(1'b0, 1'b1, 1'b0);
    rdall();
    $display("test agc done");
    clen = 10'h190;
    smp(1'b0, 1'b0, 1'b0);
    // err still shows the underflow of the last finished sample
    xfer(rd(`ADDR_ANGLE), 16'hC000, 16'hC000);
    cyc(420);
    clen = 10'h014;
    rdall();
    $display("test busy done");
    wr(`ADDR_CONFIG, 8'h04);
    smp(1'b1, 1'b0, 1'b0);
    rdall();
    r = 5'($unsigned($random(seed)) % 18);
    wr(`ADDR_GAIN, 8'hFF);
    rdall();
    wr(`ADDR_GAIN, {3'b000, r});
    wr(`ADDR_ANGLE, 8'hFF);
    wr(`ADDR_CHIP_ID, 8'hFF);
    wr(`ADDR_CONFIG, 8'hFF);
    xfer({2'b00, `ADDR_CONFIG, 8'h00}, ex(`ADDR_CONFIG), 16'hFFFF);
    rdall();
    chk({11'h000, gain_level}, {11'h000, g});
    chk({9'h000, rs, sf, 1'b0, io, ao, 1'b0, lp}, {8'h00, ec});
    chk(16'(n_st), 16'(e_st));
    $display("test writes done");
    give_verdict;
  end
endmodule
